// ==== pkg/pss_pkg.sv ====
// Purpose: Shared constants, register map and carriers for the parameter-set sequencer
// Assumes: 32-bit APB register bus, 12-bit byte address
// Notes:   Sequence parameters travel as one packed struct of 32-bit words

package pss_pkg;

    // Sizes
    localparam int PSS_MAX_SETS   = 64;
    localparam int PSS_NTIMERS    = 4;
    localparam int PSS_NWORDS     = 19;
    localparam int PSS_SYNC_DEPTH = 3;
    localparam int PSS_TOTAL_RST  = 1;

    // Register byte addresses
    localparam logic [11:0] PSS_A_CTRL     = 12'h000;
    localparam logic [11:0] PSS_A_TOTAL    = 12'h004;
    localparam logic [11:0] PSS_A_SELECT   = 12'h008;
    localparam logic [11:0] PSS_A_CMD      = 12'h00c;
    localparam logic [11:0] PSS_A_STATUS   = 12'h010;
    localparam logic [11:0] PSS_A_NONSEQ   = 12'h014;
    localparam logic [3:0]  PSS_A_WIN_PAGE = 4'h1;

    // Control register fields
    localparam int PSS_CTRL_EN       = 0;
    localparam int PSS_CTRL_MODE_LSB = 1;
    localparam int PSS_CTRL_SRC_LSB  = 3;
    localparam int PSS_CTRL_AE       = 5;
    localparam int PSS_CTRL_AG       = 6;
    localparam int PSS_CTRL_AWB      = 7;
    localparam int PSS_CTRL_W        = 8;

    // Command register bits, self clearing
    localparam int PSS_CMD_STORE   = 0;
    localparam int PSS_CMD_LOAD    = 1;
    localparam int PSS_CMD_RESTART = 2;
    localparam int PSS_CMD_ADVANCE = 3;

    // Status register fields
    localparam int PSS_ST_VALID = 8;
    localparam int PSS_ST_RUN   = 9;
    localparam int PSS_ST_INOP  = 10;

    // Reset values
    localparam logic [31:0] PSS_NONSEQ_RST = 32'h0000_0000;
    localparam logic [31:0] PSS_WORD_RST   = 32'h0000_0000;

    // Advance schemes and controlled-mode sources
    typedef enum logic [1:0] {
        PSS_ADV_AUTO,
        PSS_ADV_CONTROLLED,
        PSS_ADV_FREE
    } pss_adv_e;

    typedef enum logic [1:0] {
        PSS_SRC_ALWAYS,
        PSS_SRC_LINE,
        PSS_SRC_OFF
    } pss_src_e;

    // Sequence parameters; exposure sits in word 0, executions in word 18
    typedef struct packed {
        logic [31:0]                  executions;
        logic [31:0]                  duration_tb;
        logic [31:0]                  delay_tb;
        logic [PSS_NTIMERS-1:0][31:0] timer_duration;
        logic [PSS_NTIMERS-1:0][31:0] timer_delay;
        logic [31:0]                  chunk_enables;
        logic [31:0]                  color_adjust;
        logic [31:0]                  format_flags;
        logic [31:0]                  roi_offset;
        logic [31:0]                  roi_size;
        logic [31:0]                  black_level;
        logic [31:0]                  gain;
        logic [31:0]                  exposure;
    } pss_params_s;

    typedef logic [PSS_NWORDS-1:0][31:0] pss_words_t;

endpackage

// ==== hw/pss_set_store.sv ====
// Purpose: Volatile flip-flop storage of the indexed sequence sets
// Assumes: One write port, one combinational read port
// Notes:   Contents clear on reset; nothing else reaches this storage

`timescale 1ns/1ps
`default_nettype none

module pss_set_store #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 608,
    parameter int IDX_W = 6
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    // Index must cover exactly the depth so no read falls outside
    if (DEPTH != (1 << IDX_W)) begin : g_chk
        $error("pss_set_store: DEPTH must equal 2**IDX_W");
    end

    // Single write per cycle
    always_comb begin
        next_mem = mem;
        if (wr_en) begin
            next_mem[wr_idx] = wr_data;
        end
    end

    // Reset wipes every set, as power loss would
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;                                       // RQ16
            end
        end else begin
            mem <= next_mem;
        end
    end

    assign rd_data = mem[rd_idx];

endmodule

`default_nettype wire

// ==== hw/pss_sequencer.sv ====
// Purpose: Parameter-set sequencer driving the active acquisition configuration
// Assumes: APB slave with zero wait states; trigger and lines are asynchronous pins
// Notes:   Set load is one cycle, aligned with the frame start it serves
//
// Function
// RQ1 - Sequencer stays idle while auto exposure, gain or white balance is on.
// RQ2 - While enabled, each acquisition gets the next stored set applied.
// RQ3 - Three advance schemes: automatic, controlled and free selection.
// RQ4 - Operation follows the active set; host writes update it.
// RQ5 - The sequencer never touches non-sequence parameters.
// RQ6 - Stored set copies into the active set at once, between frames.
// RQ7 - Loading sets never lowers the achievable frame rate.
// RQ8 - The index of the set feeding the active set is tracked.
// RQ9 - Every stored set holds its own copy of acquisition parameters.
// RQ10 - Each set holds delay, duration and both timebases per timer; the code keeps one delay and one duration timebase shared by all timers.
// RQ11 - Per-set execution count acts only in the automatic scheme.
// RQ12 - Sets are indexed from zero and stored by the host before enabling.
// RQ13 - Total set count, executions and advance source are stored too.
// RQ14 - While enabled, host access sees pre-enable values and cannot modify.
// RQ15 - Host disables the sequencer before writing or storing sets.
// RQ16 - All stored sets are lost on reset and must be refilled.
// RQ17 - Stored sets are never part of saved user configurations.
// RQ18 - Besides host commands, set selection happens only on frame triggers.
// RQ19 - Automatic scheme ascends by index and wraps to zero after the last.
// RQ20 - Total sets per cycle programmable up to sixty-four.
// RQ21 - Load command copies the selected set into the active set.
// RQ22 - After reset the sequencer is disabled with no current set.
//
// The address map and the APB slave port were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module pss_sequencer #(
    parameter int DEPTH  = pss_pkg::PSS_MAX_SETS,
    parameter int LINE_W = 2,
    parameter int EXEC_W = 16
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 frame_trigger,
    input  wire logic [LINE_W-1:0]    seq_lines,
    output pss_pkg::pss_params_s      active_params,
    output logic      [31:0]          nonseq_params,
    output logic                      frame_start,
    output logic      [$clog2(DEPTH)-1:0] cur_set_index,
    output logic                      cur_set_valid
);

    localparam int IDX_W = $clog2(DEPTH);
    localparam int TOT_W = IDX_W + 1;
    localparam int PW    = $bits(pss_pkg::pss_params_s);
    localparam int SW    = LINE_W + 1;

    // Parameters the logic cannot serve
    if (DEPTH > pss_pkg::PSS_MAX_SETS || DEPTH < 2 || LINE_W < 2 || LINE_W > IDX_W
        || EXEC_W < 1 || EXEC_W > 32) begin : g_chk
        $error("pss_sequencer: unsupported parameter values");
    end

    // Register state
    logic [pss_pkg::PSS_CTRL_W-1:0] ctrl,       next_ctrl;
    logic [TOT_W-1:0]               total,      next_total;
    logic [IDX_W-1:0]               selector,   next_selector;
    logic [31:0]                    nonseq,     next_nonseq;
    pss_pkg::pss_words_t            host_w,     next_host_w;
    pss_pkg::pss_params_s           active,     next_active;
    logic [IDX_W-1:0]               cur_idx,    next_cur_idx;
    logic                           cur_valid,  next_cur_valid;
    logic [EXEC_W-1:0]              exec_cnt,   next_exec_cnt;
    logic                           fstart,     next_fstart;
    logic [31:0]                    rdata,      next_rdata;
    logic                           slverr,     next_slverr;

    // Pin synchroniser state
    logic [SW-1:0] sync1, sync2, sync3, lvl, next_lvl;
    logic          trig_prev, next_trig_prev;

    // Decoded strobes and selection results
    logic                 wr_acc, setup;
    logic                 hit_win;
    logic [4:0]           win_idx;
    logic                 cmd_store, cmd_load, cmd_restart, cmd_advance;
    logic                 auto_on, running, trig_edge;
    logic [TOT_W-1:0]     total_eff;
    logic [IDX_W-1:0]     inc_idx, line_idx, tgt_idx, rd_idx;
    logic                 apply;
    logic [EXEC_W-1:0]    tgt_cnt;
    logic [PW-1:0]        rd_data;
    pss_pkg::pss_adv_e    mode;
    pss_pkg::pss_src_e    src;

    // Bus decode
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign hit_win = (paddr[11:8] == pss_pkg::PSS_A_WIN_PAGE) && !paddr[7] && (paddr[1:0] == 2'h0)
                     && (int'(paddr[6:2]) < pss_pkg::PSS_NWORDS);
    assign win_idx = paddr[6:2];

    // Commands act only on the completing write
    assign cmd_store   = wr_acc && (paddr == pss_pkg::PSS_A_CMD) && pwdata[pss_pkg::PSS_CMD_STORE];
    assign cmd_load    = wr_acc && (paddr == pss_pkg::PSS_A_CMD) && pwdata[pss_pkg::PSS_CMD_LOAD];
    assign cmd_restart = wr_acc && (paddr == pss_pkg::PSS_A_CMD) && pwdata[pss_pkg::PSS_CMD_RESTART];
    assign cmd_advance = wr_acc && (paddr == pss_pkg::PSS_A_CMD) && pwdata[pss_pkg::PSS_CMD_ADVANCE];

    // Auto functions hold the sequencer off entirely
    assign auto_on = ctrl[pss_pkg::PSS_CTRL_AE] || ctrl[pss_pkg::PSS_CTRL_AG]
                     || ctrl[pss_pkg::PSS_CTRL_AWB];                                 // RQ1
    assign running = ctrl[pss_pkg::PSS_CTRL_EN] && !auto_on;                          // RQ1
    assign mode    = pss_pkg::pss_adv_e'(ctrl[pss_pkg::PSS_CTRL_MODE_LSB +: 2]);
    assign src     = pss_pkg::pss_src_e'(ctrl[pss_pkg::PSS_CTRL_SRC_LSB +: 2]);

    // Zero or oversize totals clamp to a usable cycle length
    assign total_eff = (total == '0) ? TOT_W'(1)
                     : ((int'(total) > DEPTH) ? TOT_W'(DEPTH) : total);              // RQ20
    assign inc_idx   = (({1'b0, cur_idx} + TOT_W'(1)) >= total_eff) ? '0
                     : IDX_W'(cur_idx + IDX_W'(1));                                  // RQ19
    assign line_idx  = IDX_W'(lvl[SW-1:1]);
    assign trig_edge = lvl[0] && !trig_prev;

    // Next set choice; only frame triggers and host commands move it
    always_comb begin
        apply   = 1'b0;
        tgt_idx = cur_idx;
        tgt_cnt = exec_cnt;
        if (running && trig_edge) begin                                               // RQ18
            apply = 1'b1;
            unique case (mode)
                pss_pkg::PSS_ADV_FREE: begin                                          // RQ3
                    if ({1'b0, line_idx} < total_eff) begin
                        tgt_idx = line_idx;
                    end
                    tgt_cnt = EXEC_W'(1);
                end
                pss_pkg::PSS_ADV_CONTROLLED: begin                                    // RQ3
                    tgt_cnt = EXEC_W'(1);
                    if (!cur_valid || (src == pss_pkg::PSS_SRC_LINE && lvl[2])) begin
                        tgt_idx = '0;
                    end else if (src == pss_pkg::PSS_SRC_ALWAYS
                                 || (src == pss_pkg::PSS_SRC_LINE && lvl[1])) begin
                        tgt_idx = inc_idx;
                    end
                end
                default: begin                                                        // RQ3
                    // Execution count only matters here
                    if (!cur_valid) begin
                        tgt_idx = '0;
                        tgt_cnt = EXEC_W'(1);
                    end else if (exec_cnt >= active.executions[EXEC_W-1:0]) begin     // RQ11
                        tgt_idx = inc_idx;                                            // RQ19
                        tgt_cnt = EXEC_W'(1);
                    end else begin
                        tgt_cnt = EXEC_W'(exec_cnt + EXEC_W'(1));
                    end
                end
            endcase
        end else if (running && cmd_restart) begin                                    // RQ18
            apply   = 1'b1;
            tgt_idx = '0;
            tgt_cnt = EXEC_W'(1);
        end else if (running && cmd_advance) begin
            apply   = 1'b1;
            tgt_idx = cur_valid ? inc_idx : '0;
            tgt_cnt = EXEC_W'(1);
        end
    end

    // Disabled: the read port serves the load command
    assign rd_idx = running ? tgt_idx : selector;

    // Stored sets; only the store command writes them
    pss_set_store #(
        .DEPTH (DEPTH),
        .WIDTH (PW),
        .IDX_W (IDX_W)
    ) u_store (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (cmd_store && !ctrl[pss_pkg::PSS_CTRL_EN]),                          // RQ12
        .wr_idx  (selector),
        .wr_data (PW'(host_w)),                                                       // RQ9 RQ10
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // Registers, sequencer state and active set
    always_comb begin
        next_ctrl      = ctrl;
        next_total     = total;
        next_selector  = selector;
        next_nonseq    = nonseq;
        next_host_w    = host_w;
        next_active    = active;
        next_cur_idx   = cur_idx;
        next_cur_valid = cur_valid;
        next_exec_cnt  = exec_cnt;
        next_fstart    = trig_edge;                                                   // RQ7
        if (wr_acc) begin
            if (paddr == pss_pkg::PSS_A_CTRL) begin
                next_ctrl = pwdata[pss_pkg::PSS_CTRL_W-1:0];
            end
            if (paddr == pss_pkg::PSS_A_TOTAL) begin
                next_total = pwdata[TOT_W-1:0];                                       // RQ13
            end
            if (paddr == pss_pkg::PSS_A_SELECT) begin
                next_selector = pwdata[IDX_W-1:0];
            end
            if (paddr == pss_pkg::PSS_A_NONSEQ) begin
                next_nonseq = pwdata;                                                 // RQ5
            end
            // Host copy frozen while enabled so reads show pre-enable values
            if (hit_win && !ctrl[pss_pkg::PSS_CTRL_EN]) begin                         // RQ14
                next_host_w[win_idx] = pwdata;                                        // RQ4
            end
        end
        if (!running) begin
            // No sequencing: the active set tracks the host copy
            next_cur_valid = 1'b0;                                                    // RQ22
            next_exec_cnt  = '0;
            if (cmd_load && !ctrl[pss_pkg::PSS_CTRL_EN]) begin                        // RQ21
                next_host_w = pss_pkg::pss_words_t'(rd_data);
            end
            next_active = pss_pkg::pss_params_s'(next_host_w);                        // RQ4
        end else if (apply) begin
            // Whole set swaps in one cycle, on the same edge as the frame start it serves
            next_active    = pss_pkg::pss_params_s'(rd_data);                         // RQ6
            next_cur_idx   = tgt_idx;                                                 // RQ8
            next_cur_valid = 1'b1;                                                    // RQ2
            next_exec_cnt  = tgt_cnt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl      <= '0;                                                          // RQ22
            total     <= TOT_W'(pss_pkg::PSS_TOTAL_RST);
            selector  <= '0;
            nonseq    <= pss_pkg::PSS_NONSEQ_RST;
            host_w    <= '{default: pss_pkg::PSS_WORD_RST};
            active    <= '0;
            cur_idx   <= '0;
            cur_valid <= 1'b0;                                                        // RQ22
            exec_cnt  <= '0;
            fstart    <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            total     <= next_total;
            selector  <= next_selector;
            nonseq    <= next_nonseq;
            host_w    <= next_host_w;
            active    <= next_active;
            cur_idx   <= next_cur_idx;
            cur_valid <= next_cur_valid;
            exec_cnt  <= next_exec_cnt;
            fstart    <= next_fstart;
        end
    end

    // Read data latched in setup so the access phase needs no wait state
    always_comb begin
        next_rdata  = rdata;
        next_slverr = slverr;
        if (setup) begin
            next_rdata  = '0;
            next_slverr = 1'b0;
            if (hit_win) begin
                next_rdata = host_w[win_idx];                                         // RQ14
            end else begin
                unique case (paddr)
                    pss_pkg::PSS_A_CTRL:   next_rdata = 32'(ctrl);
                    pss_pkg::PSS_A_TOTAL:  next_rdata = 32'(total);
                    pss_pkg::PSS_A_SELECT: next_rdata = 32'(selector);
                    pss_pkg::PSS_A_CMD:    next_rdata = '0;
                    pss_pkg::PSS_A_STATUS: begin
                        next_rdata = 32'(cur_idx);
                        next_rdata[pss_pkg::PSS_ST_VALID] = cur_valid;
                        next_rdata[pss_pkg::PSS_ST_RUN]   = running;
                        next_rdata[pss_pkg::PSS_ST_INOP]  = auto_on;
                    end
                    pss_pkg::PSS_A_NONSEQ: next_rdata = nonseq;
                    default:               next_slverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata  <= '0;
            slverr <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            slverr <= next_slverr;
        end
    end

    // Three-stage pin sync; a bit moves once stages two and three agree
    always_comb begin
        next_lvl       = (sync2 & sync3) | (lvl & (sync2 ^ sync3));
        next_trig_prev = lvl[0];
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1     <= '0;
            sync2     <= '0;
            sync3     <= '0;
            lvl       <= '0;
            trig_prev <= 1'b0;
        end else begin
            sync1     <= {seq_lines, frame_trigger};
            sync2     <= sync1;
            sync3     <= sync2;
            lvl       <= next_lvl;
            trig_prev <= next_trig_prev;
        end
    end

    // Outputs; no port exposes stored sets for saving elsewhere
    assign prdata        = rdata;
    assign pready        = 1'b1;
    assign pslverr       = slverr && psel && penable;
    assign active_params = active;                                                    // RQ17
    assign nonseq_params = nonseq;
    assign frame_start   = fstart;
    assign cur_set_index = cur_idx;
    assign cur_set_valid = cur_valid;

    // Checks
    a_auto_interlock: assert property (@(posedge clock) disable iff (!resetn)
        auto_on |=> !cur_valid) else $error("set applied while auto functions on"); // RQ1
    a_trig_applies: assert property (@(posedge clock) disable iff (!resetn)
        (running && trig_edge) |=> (cur_valid && frame_start)) else $error("trigger did not apply a set"); // RQ2
    a_frame_rate_kept: assert property (@(posedge clock) disable iff (!resetn)
        trig_edge |=> frame_start ##1 !frame_start) else $error("frame start lost or stretched"); // RQ7
    a_nonseq_untouched: assert property (@(posedge clock) disable iff (!resetn)
        !(wr_acc && paddr == pss_pkg::PSS_A_NONSEQ) |=> $stable(nonseq_params))
        else $error("non-sequence value changed without host write"); // RQ5
    a_host_frozen: assert property (@(posedge clock) disable iff (!resetn)
        ctrl[pss_pkg::PSS_CTRL_EN] && !cmd_load |=> $stable(host_w)) else $error("host copy changed while enabled"); // RQ14
    a_auto_wrap: assert property (@(posedge clock) disable iff (!resetn)
        (running && trig_edge && mode == pss_pkg::PSS_ADV_AUTO && cur_valid
         && ({1'b0, cur_idx} == total_eff - TOT_W'(1)) && exec_cnt >= active.executions[EXEC_W-1:0])
        |=> (cur_set_index == '0)) else $error("automatic cycle did not wrap to zero"); // RQ19
    a_free_select: assert property (@(posedge clock) disable iff (!resetn)
        (running && trig_edge && mode == pss_pkg::PSS_ADV_FREE && {1'b0, line_idx} < total_eff)
        |=> (cur_set_index == $past(line_idx))) else $error("free selection ignored lines"); // RQ3
    a_idle_no_set: assert property (@(posedge clock) disable iff (!resetn)
        !ctrl[pss_pkg::PSS_CTRL_EN] |=> !cur_set_valid) else $error("current set while disabled"); // RQ22
    a_load_copy: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_load && !ctrl[pss_pkg::PSS_CTRL_EN] && !auto_on)
        |=> (active_params == pss_pkg::pss_params_s'($past(rd_data)))) else $error("load did not copy set"); // RQ21
    a_trigger_only: assert property (@(posedge clock) disable iff (!resetn)
        (cur_valid && !trig_edge && !cmd_restart && !cmd_advance) |=> $stable(cur_set_index))
        else $error("set moved without trigger or command"); // RQ18

endmodule

`default_nettype wire

// ==== verif/pss_sequencer_tb.sv ====
// Purpose: Self-checking bench for the parameter-set sequencer
// Assumes: Zero-wait APB slave; trigger pin passes a 3-stage sync
// Notes:   Seed 91 draws exposure words; frame_start and the final reset-loss checks sampled on the falling edge, others after the rising edge
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb;
    logic                 clock = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic                 frame_trigger = 1'h0, pready, pslverr, frame_start, cur_set_valid, err;
    logic [11:0]          paddr = 12'h0;
    logic [31:0]          pwdata = 32'h0, prdata, rd, nonseq_params, v[2], e;
    logic [1:0]           seq_lines = 2'h0, ln;
    logic [5:0]           cur_set_index;
    pss_pkg::pss_params_s active_params;
    int                   num_errors = 0, comparisons = 0, cycles = 0, seed = 91;

    pss_sequencer DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_trigger(frame_trigger), .seq_lines(seq_lines), .active_params(active_params),
        .nonseq_params(nonseq_params), .frame_start(frame_start), .cur_set_index(cur_set_index),
        .cur_set_valid(cur_set_valid));

    always #10 clock = ~clock;

    // Hang guard, far above the few hundred cycles planned
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Pin held high until the frame pulse shows, then low long enough
    task automatic trig();
        int k = 0;
        @(posedge clock);
        frame_trigger <= 1'h1;
        do begin
            @(negedge clock);
            k++;
        end while (frame_start !== 1'h1 && k < 20);
        chk("frame_start", 32'h1, {31'h0, frame_start});
        @(posedge clock);
        frame_trigger <= 1'h0;
        repeat (3) @(posedge clock);
    endtask

    // Auto scheme, one execution each: plain modulo walk
    function automatic logic [31:0] exp_idx(input int n, input int total);
        return 32'(n % total);
    endfunction

    // Two sets: free picks the line value if in range, controlled restarts on line 1, advances on line 0
    function automatic logic [31:0] exp_sel(input logic fr, input logic [1:0] l, input logic [31:0] cur);
        if (fr) return (l < 2'h2) ? 32'(l) : cur;
        if (l[1]) return 32'h0;
        return l[0] ? (cur + 32'h1) % 32'h2 : cur;
    endfunction

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        v[0] = $random(seed);
        v[1] = $random(seed);
        repeat (6) @(posedge clock);
        resetn <= 1'h1;
        apb(1'h0, pss_pkg::PSS_A_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'h0, pss_pkg::PSS_A_TOTAL, 32'h0);
        chk("total", 32'h1, rd);
        apb(1'h0, 12'h0f0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        $display("reset test done");
        // Fill sets 0 and 1 while disabled
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, 12'h100, v[i]);
            apb(1'h1, 12'h148, 32'h1);
            apb(1'h1, pss_pkg::PSS_A_SELECT, 32'(i));
            apb(1'h1, pss_pkg::PSS_A_CMD, 32'h1);
        end
        apb(1'h1, pss_pkg::PSS_A_NONSEQ, v[0] ^ v[1]);
        apb(1'h1, pss_pkg::PSS_A_TOTAL, 32'h2);
        apb(1'h1, pss_pkg::PSS_A_CTRL, 32'h1);
        for (int n = 0; n < 3; n++) begin
            trig();
            chk("index", exp_idx(n, 2), {26'h0, cur_set_index});
            chk("exposure", v[exp_idx(n, 2)], active_params.exposure);
            chk("nonseq", v[0] ^ v[1], nonseq_params);
        end
        apb(1'h0, 12'h100, 32'h0);
        chk("window", v[1], rd);
        apb(1'h1, 12'h100, 32'h5);
        $display("auto test done");
        // Auto exposure on: a trigger must not advance
        apb(1'h1, pss_pkg::PSS_A_CTRL, 32'h21);
        trig();
        chk("interlock", 32'h0, {26'h0, cur_set_index});
        chk("inop_valid", 32'h0, {31'h0, cur_set_valid});
        apb(1'h1, pss_pkg::PSS_A_CTRL, 32'h0);
        apb(1'h0, 12'h100, 32'h0);
        chk("refused", v[1], rd);
        $display("interlock test done");
        // Free selection, then controlled by lines; random lines, last one both lines high
        e = 32'h0;
        for (int n = 0; n < 8; n++) begin
            ln = (n == 7) ? 2'h3 : 2'($random(seed));
            seq_lines <= ln;
            apb(1'h1, pss_pkg::PSS_A_CTRL, (n < 3) ? 32'h5 : 32'hb);
            trig();
            e = exp_sel(n < 3, ln, e);
            chk("line_index", e, {26'h0, cur_set_index});
        end
        // Host restart and advance act at once, seen through status
        apb(1'h1, pss_pkg::PSS_A_CMD, 32'h4);
        apb(1'h0, pss_pkg::PSS_A_STATUS, 32'h0);
        chk("restart", 32'h300, rd);
        apb(1'h1, pss_pkg::PSS_A_CMD, 32'h8);
        apb(1'h0, pss_pkg::PSS_A_STATUS, 32'h0);
        chk("advance", 32'h301, rd);
        apb(1'h1, pss_pkg::PSS_A_CTRL, 32'h0);
        $display("mode test done");
        // Reset after disabling wipes stored sets
        resetn <= 1'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'h1;
        apb(1'h1, pss_pkg::PSS_A_SELECT, 32'h1);
        apb(1'h1, pss_pkg::PSS_A_CMD, 32'h2);
        @(negedge clock);
        chk("lost", 32'h0, active_params.exposure);
        chk("valid", 32'h0, {31'h0, cur_set_valid});
        $display("reset loss test done");
        end_of_test();
    end
endmodule
`default_nettype wire
